// ===== rtl/fmc_pkg.sv
package fmc_pkg;

  // ----------------------------------------------------------------------
  // Divider and message geometry
  // ----------------------------------------------------------------------
  localparam int          REM_W      = 15;
  localparam logic [14:0] POLY_TAPS  = 15'h6815;  // x14 x13 x11 x4 x2 1.
  localparam logic [14:0] REM_ZERO   = 15'h0000;
  localparam logic [14:0] LAST_INV   = 15'h0001;  // Last remainder bit.
  localparam int          BYTE_W     = 8;
  localparam int          CKS_W      = 16;
  localparam int          FIFO_DEPTH = 8;

  // ----------------------------------------------------------------------
  // Counter limits
  // ----------------------------------------------------------------------
  localparam logic [2:0]  BIT_LAST   = 3'h7;   // Eighth bit of a byte.
  localparam logic [2:0]  BYTE_LAST  = 3'h5;   // Sixth byte of a block.
  localparam logic [3:0]  CKS_LAST   = 4'hf;   // Sixteenth check bit.
  localparam logic [5:0]  RX_INV_IDX = 6'h3e;  // Index of received bit 63.
  localparam logic [5:0]  RX_PAR_IDX = 6'h3f;  // Index of received bit 64.

  // ----------------------------------------------------------------------
  // Transmit sequencer states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_DATA = 4'h2,
    TX_LOAD = 4'h4,
    TX_CKS  = 4'h8
  } fmc_tx_st_t;

endpackage : fmc_pkg

// ===== rtl/fmc_stream_if.sv
`timescale 1ns/1ps
interface fmc_stream_if #(
  parameter int W = 8
);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;

  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface : fmc_stream_if

// ===== rtl/fmc_fifo.sv
`timescale 1ns/1ps
module fmc_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  fmc_stream_if.snk wr,
  fmc_stream_if.src rd
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wptr;
    logic [AW-1:0]           rptr;
    logic [AW:0]             cnt;
  } fmc_fifo_st_t;

  fmc_fifo_st_t s_ff;
  fmc_fifo_st_t nxt_s;
  logic         push;
  logic         pop;

  // ----------------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------------
  // Full and empty come straight from the occupancy count.
  assign wr.ready = (s_ff.cnt != (AW+1)'(DEPTH));
  assign rd.valid = (s_ff.cnt != '0);
  assign rd.data  = s_ff.mem[s_ff.rptr];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  // Pointers wrap by hand so that a depth off a power of two still works.
  always_comb begin
    nxt_s = s_ff;
    if (push) begin
      nxt_s.mem[s_ff.wptr] = wr.data;
      nxt_s.wptr = (s_ff.wptr == AW'(DEPTH-1)) ? '0 : s_ff.wptr + AW'(1);
    end
    if (pop) begin
      nxt_s.rptr = (s_ff.rptr == AW'(DEPTH-1)) ? '0 : s_ff.rptr + AW'(1);
    end
    if (push && !pop) begin
      nxt_s.cnt = s_ff.cnt + (AW+1)'(1);
    end else if (pop && !push) begin
      nxt_s.cnt = s_ff.cnt - (AW+1)'(1);
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

endmodule : fmc_fifo

// ===== rtl/fmc_div.sv
`timescale 1ns/1ps
module fmc_div (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clr,
  input  wire logic        step,
  input  wire logic        din,
  input  wire logic        par_in,
  output logic [14:0]      rem,
  output logic             par
);

  typedef struct packed {
    logic [14:0] rem;
    logic        par;
  } fmc_div_st_t;

  fmc_div_st_t s_ff;
  fmc_div_st_t nxt_s;
  logic        fb;

  // ----------------------------------------------------------------------
  // Serial modulo-2 divider
  // ----------------------------------------------------------------------
  // The remainder is of the message times x^15, so the check bits can be
  // appended as they are and the far divider lands on zero.
  always_comb begin
    nxt_s = s_ff;
    fb    = din ^ s_ff.rem[14];
    if (clr) begin
      nxt_s = '0;
    end else if (step) begin
      nxt_s.rem = {s_ff.rem[13:0], 1'b0} ^
                  (fb ? fmc_pkg::POLY_TAPS : fmc_pkg::REM_ZERO);
      nxt_s.par = s_ff.par ^ par_in;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign rem = s_ff.rem;
  assign par = s_ff.par;

endmodule : fmc_div

// ===== rtl/fmc_codec.sv
`timescale 1ns/1ps
module fmc_codec (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        bit_tick,
  input  wire logic        cksum_ins_en,
  input  wire logic [7:0]  tx_byte,
  input  wire logic        tx_byte_valid,
  output logic             tx_byte_ready,
  output logic             tx_bit,
  output logic             tx_bit_stb,
  output logic             tx_idle,
  input  wire logic        rx_bit,
  input  wire logic        rx_bit_stb,
  input  wire logic        rx_msg_start,
  output logic             cksum_true,
  output logic [15:0]      syndrome,
  output logic             syndrome_stb
);

  typedef struct packed {
    fmc_pkg::fmc_tx_st_t st;
    logic [7:0]          sr;
    logic [2:0]          bit_cnt;
    logic [2:0]          byte_cnt;
    logic [15:0]         cks;
    logic [3:0]          cks_cnt;
    logic                bit_out;
    logic                bit_stb;
    logic [5:0]          rx_cnt;
    logic [15:0]         syn;
    logic                cks_true;
    logic                syn_stb;
  } fmc_codec_st_t;

  fmc_codec_st_t s_ff;
  fmc_codec_st_t nxt_s;
  logic [1:0]    rst_sync_ff;
  logic          rst_n;

  fmc_stream_if #(.W(fmc_pkg::BYTE_W)) in_if ();
  fmc_stream_if #(.W(fmc_pkg::BYTE_W)) out_if ();

  logic        tx_clr;
  logic        tx_step;
  logic [14:0] tx_rem;
  logic        tx_par;
  logic        rx_clr;
  logic        rx_step;
  logic        rx_din;
  logic [14:0] rx_rem;
  logic        rx_par;
  logic        rx_end;
  logic        perr;
  logic [14:0] chk;

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  // The release is retimed so that every flop leaves reset on one edge.
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Syndrome bit order: the first remainder bit out is the first syndrome.
  function automatic logic [14:0] fmc_rev15(input logic [14:0] v);
    logic [14:0] r;
    r = '0;
    for (int i = 0; i < fmc_pkg::REM_W; i++) begin
      r[i] = v[fmc_pkg::REM_W-1-i];
    end
    return r;
  endfunction : fmc_rev15

  // ----------------------------------------------------------------------
  // Transmit byte buffer
  // ----------------------------------------------------------------------
  // Host bytes queue here; a full buffer stalls the host by tx_byte_ready.
  assign in_if.data    = tx_byte;
  assign in_if.valid   = tx_byte_valid;
  assign tx_byte_ready = in_if.ready;

  fmc_fifo #(
    .W     (fmc_pkg::BYTE_W),
    .DEPTH (fmc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk   (mclk),
    .rst_n (rst_n),
    .wr    (in_if),
    .rd    (out_if)
  );

  // ----------------------------------------------------------------------
  // Dividers
  // ----------------------------------------------------------------------
  // Transmit side steps on every message bit it sends.
  assign tx_step = (s_ff.st == fmc_pkg::TX_DATA) && bit_tick;

  fmc_div u_tx_div (
    .clk    (mclk),
    .rst_n  (rst_n),
    .clr    (tx_clr),
    .step   (tx_step),
    .din    (s_ff.sr[7]),
    .par_in (s_ff.sr[7]),
    .rem    (tx_rem),
    .par    (tx_par)
  );

  // Receive side inverts the 63rd bit for the divider but not for parity.
  assign rx_end  = rx_bit_stb && (s_ff.rx_cnt == fmc_pkg::RX_PAR_IDX);
  assign rx_step = rx_bit_stb && !rx_end && !rx_msg_start;
  assign rx_din  = (s_ff.rx_cnt == fmc_pkg::RX_INV_IDX) ? ~rx_bit
                                                        : rx_bit;
  assign rx_clr  = rx_msg_start || rx_end;

  fmc_div u_rx_div (
    .clk    (mclk),
    .rst_n  (rst_n),
    .clr    (rx_clr),
    .step   (rx_step),
    .din    (rx_din),
    .par_in (rx_bit),
    .rem    (rx_rem),
    .par    (rx_par)
  );

  // Remainder with its last bit inverted, and the received parity check.
  assign chk  = tx_rem ^ fmc_pkg::LAST_INV;
  assign perr = rx_par ^ rx_bit;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // TX_LOAD takes one mclk after the last message bit so the divider has
  // settled; bit_tick must therefore never come on two edges in a row.
  always_comb begin
    nxt_s         = s_ff;
    nxt_s.bit_stb = 1'b0;
    nxt_s.syn_stb = 1'b0;
    out_if.ready  = 1'b0;
    tx_clr        = 1'b0;
    case (s_ff.st)
      fmc_pkg::TX_IDLE: begin
        if (out_if.valid) begin
          out_if.ready  = 1'b1;
          nxt_s.sr      = out_if.data;
          nxt_s.bit_cnt = '0;
          nxt_s.st      = fmc_pkg::TX_DATA;
        end
      end
      fmc_pkg::TX_DATA: begin
        if (bit_tick) begin
          nxt_s.bit_out = s_ff.sr[7];
          nxt_s.bit_stb = 1'b1;
          nxt_s.sr      = {s_ff.sr[6:0], 1'b0};
          nxt_s.bit_cnt = s_ff.bit_cnt + 3'h1;
          if (s_ff.bit_cnt == fmc_pkg::BIT_LAST) begin
            nxt_s.byte_cnt = s_ff.byte_cnt + 3'h1;
            if (s_ff.byte_cnt == fmc_pkg::BYTE_LAST) begin
              nxt_s.byte_cnt = '0;
              if (cksum_ins_en) begin
                nxt_s.st = fmc_pkg::TX_LOAD;
              end else begin
                tx_clr = 1'b1;
              end
            end
            if (nxt_s.st == fmc_pkg::TX_DATA) begin
              if (out_if.valid) begin
                out_if.ready = 1'b1;
                nxt_s.sr     = out_if.data;
              end else begin
                // Underrun drops the partial block; next one starts clean.
                nxt_s.st       = fmc_pkg::TX_IDLE;
                nxt_s.byte_cnt = '0;
                tx_clr         = 1'b1;
              end
            end
          end
        end
      end
      fmc_pkg::TX_LOAD: begin
        nxt_s.cks     = {chk, tx_par ^ (^chk)};
        nxt_s.cks_cnt = '0;
        nxt_s.st      = fmc_pkg::TX_CKS;
        tx_clr        = 1'b1;
      end
      fmc_pkg::TX_CKS: begin
        if (bit_tick) begin
          nxt_s.bit_out = s_ff.cks[15];
          nxt_s.bit_stb = 1'b1;
          nxt_s.cks     = {s_ff.cks[14:0], 1'b0};
          nxt_s.cks_cnt = s_ff.cks_cnt + 4'h1;
          if (s_ff.cks_cnt == fmc_pkg::CKS_LAST) begin
            nxt_s.bit_cnt = '0;
            if (out_if.valid) begin
              out_if.ready = 1'b1;
              nxt_s.sr     = out_if.data;
              nxt_s.st     = fmc_pkg::TX_DATA;
            end else begin
              nxt_s.st = fmc_pkg::TX_IDLE;
            end
          end
        end
      end
      default: begin
        nxt_s.st = fmc_pkg::TX_IDLE;
        tx_clr   = 1'b1;
      end
    endcase

    // Receive framing: a start pulse beats a bit strobe in the same cycle.
    if (rx_msg_start) begin
      nxt_s.rx_cnt = '0;
    end else if (rx_end) begin
      nxt_s.rx_cnt   = '0;
      nxt_s.syn      = {perr, fmc_rev15(rx_rem)};
      nxt_s.cks_true = (rx_rem == fmc_pkg::REM_ZERO) && !perr;
      nxt_s.syn_stb  = 1'b1;
    end else if (rx_bit_stb) begin
      nxt_s.rx_cnt = s_ff.rx_cnt + 6'h01;
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_ff    <= '0;
      s_ff.st <= fmc_pkg::TX_IDLE;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign tx_bit       = s_ff.bit_out;
  assign tx_bit_stb   = s_ff.bit_stb;
  assign tx_idle      = (s_ff.st == fmc_pkg::TX_IDLE);
  assign cksum_true   = s_ff.cks_true;
  assign syndrome     = s_ff.syn;
  assign syndrome_stb = s_ff.syn_stb;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_rx_end;
    rx_bit_stb && (s_ff.rx_cnt == fmc_pkg::RX_PAR_IDX) && !rx_msg_start;
  endsequence

  sequence s_tx_last;
    (s_ff.st == fmc_pkg::TX_DATA) && bit_tick &&
    (s_ff.bit_cnt == fmc_pkg::BIT_LAST) &&
    (s_ff.byte_cnt == fmc_pkg::BYTE_LAST);
  endsequence

  // Match flag and syndrome must agree whenever a result is published.
  property p_rx_match;
    syndrome_stb |-> (cksum_true == (syndrome == 16'h0000));
  endproperty
  a_rx_match: assert property (p_rx_match)
    else $error("checksum flag disagrees with syndrome");

  property p_rx_rem;
    s_rx_end |=> syndrome_stb &&
      ((syndrome[14:0] == 15'h0000) == ($past(rx_rem) == 15'h0000));
  endproperty
  a_rx_rem: assert property (p_rx_rem)
    else $error("syndrome does not reflect receive remainder");

  property p_rx_par;
    s_rx_end |=> (syndrome[15] == $past(rx_par ^ rx_bit));
  endproperty
  a_rx_par: assert property (p_rx_par)
    else $error("parity error bit wrong");

  property p_rx_inv;
    (rx_bit_stb && !rx_msg_start && (s_ff.rx_cnt == fmc_pkg::RX_INV_IDX)) |->
      (rx_din != rx_bit) && rx_step;
  endproperty
  a_rx_inv: assert property (p_rx_inv)
    else $error("bit 63 not inverted into divider");

  property p_rx_clr;
    (rx_msg_start or s_rx_end) |=> (rx_rem == 15'h0000) && !rx_par &&
      (s_ff.rx_cnt == 6'h00);
  endproperty
  a_rx_clr: assert property (p_rx_clr)
    else $error("receive divider not cleared at block start");

  property p_tx_ins;
    (s_tx_last and cksum_ins_en) |=> (s_ff.st == fmc_pkg::TX_LOAD)
      ##1 (s_ff.st == fmc_pkg::TX_CKS);
  endproperty
  a_tx_ins: assert property (p_tx_ins)
    else $error("checksum not inserted after six bytes");

  property p_tx_inv;
    (s_ff.st == fmc_pkg::TX_LOAD) |=>
      (s_ff.cks[15:1] == ($past(tx_rem) ^ 15'h0001)) &&
      (tx_rem == 15'h0000);
  endproperty
  a_tx_inv: assert property (p_tx_inv)
    else $error("check bits not inverted remainder");

  property p_tx_par;
    (s_ff.st == fmc_pkg::TX_LOAD) |=> ((^s_ff.cks) == $past(tx_par));
  endproperty
  a_tx_par: assert property (p_tx_par)
    else $error("checksum parity not even");

  property p_tx_msb;
    ((s_ff.st == fmc_pkg::TX_DATA) && bit_tick) |=>
      tx_bit_stb && (tx_bit == $past(s_ff.sr[7]));
  endproperty
  a_tx_msb: assert property (p_tx_msb)
    else $error("transmit bit not taken from byte msb");

endmodule : fmc_codec

// ===== tb/fmc_bit_partner.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Modem bit serialiser model
// ----------------------------------------------------------------------
module fmc_bit_partner (
  input  wire logic       mclk,
  input  wire logic       tick_en,
  input  wire logic       slow,
  input  wire logic       tx_bit,
  input  wire logic       tx_bit_stb,
  input  wire logic       rx_restart,
  input  wire logic [6:0] flip_pos,
  output logic            bit_tick,
  output logic            rx_bit,
  output logic            rx_bit_stb
);
  int   div_cnt  = 0;
  int   bit_cnt  = 0;

  initial begin
    bit_tick = 1'b0;
    rx_bit = 1'b0;
    rx_bit_stb = 1'b0;
  end

  // Ticks are spaced at least four clocks apart, as the codec needs two.
  // Each emitted bit is looped back at the falling edge inside its strobe,
  // so one process owns the bit count and a restart realigns it.
  // A looped-back bit is corrupted only at the position the bench names.
  always @(negedge mclk) begin
    bit_tick <= 1'b0;
    rx_bit_stb <= 1'b0;
    if (tick_en && div_cnt >= (slow ? 10 : 3)) begin
      div_cnt <= 0;
      bit_tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 1;
    end
    if (rx_restart) begin
      bit_cnt <= 0;
    end else if (tx_bit_stb === 1'b1) begin
      rx_bit_stb <= 1'b1;
      rx_bit <= tx_bit ^ (bit_cnt + 1 == flip_pos);
      bit_cnt <= (bit_cnt == 63) ? 0 : bit_cnt + 1;
    end else if (rx_bit_stb) begin
      rx_bit <= ~rx_bit;  // The line never holds a stale bit.
    end
  end
endmodule : fmc_bit_partner

// ===== tb/fmc_codec_tb_top.sv
`timescale 1ns/1ps
module fmc_codec_tb_top;
  logic        mclk;
  logic        rstn;
  logic        bit_tick;
  logic        cksum_ins_en;
  logic [7:0]  tx_byte;
  logic        tx_byte_valid;
  logic        tx_byte_ready;
  logic        tx_bit;
  logic        tx_bit_stb;
  logic        tx_idle;
  logic        rx_bit;
  logic        rx_bit_stb;
  logic        rx_msg_start;
  logic        cksum_true;
  logic [15:0] syndrome;
  logic        syndrome_stb;
  logic        tick_en;
  logic        slow;
  logic [6:0]  flip_pos;
  logic [6:0]  flips[7];
  int          n_mismatch = 0;
  int          n_tests    = 0;
  int          k;
  logic        exp_tx[$];
  logic [16:0] exp_rx[$];
  logic [14:0] m_rem;
  logic        m_par;
  logic [63:0] m_msg;
  int          m_cnt;

  fmc_codec dut (
    .mclk(mclk), .rstn(rstn), .bit_tick(bit_tick),
    .cksum_ins_en(cksum_ins_en), .tx_byte(tx_byte),
    .tx_byte_valid(tx_byte_valid), .tx_byte_ready(tx_byte_ready),
    .tx_bit(tx_bit), .tx_bit_stb(tx_bit_stb), .tx_idle(tx_idle),
    .rx_bit(rx_bit), .rx_bit_stb(rx_bit_stb),
    .rx_msg_start(rx_msg_start), .cksum_true(cksum_true),
    .syndrome(syndrome), .syndrome_stb(syndrome_stb)
  );

  fmc_bit_partner u_partner (
    .mclk(mclk), .tick_en(tick_en), .slow(slow), .tx_bit(tx_bit),
    .tx_bit_stb(tx_bit_stb), .rx_restart(rx_msg_start),
    .flip_pos(flip_pos), .bit_tick(bit_tick), .rx_bit(rx_bit),
    .rx_bit_stb(rx_bit_stb)
  );

  // ----------------------------------------------------------------------
  // Reference model
  // ----------------------------------------------------------------------
  function automatic logic [14:0] div_step(logic [14:0] r, logic d);
    return {r[13:0], 1'b0} ^ ((r[14] ^ d) ? fmc_pkg::POLY_TAPS : 15'h0000);
  endfunction : div_step

  task automatic model_clear();
    m_rem = 15'h0000;
    m_par = 1'b0;
    m_msg = 64'h0;
    m_cnt = 0;
  endtask : model_clear

  task automatic put_bit(input logic b);
    exp_tx.push_back(b);
    m_par ^= b;
    m_msg = {m_msg[62:0], b};
  endtask : put_bit

  // The checker sees the looped-back message, corrupted where asked.
  task automatic expect_rx();
    logic [63:0] v;
    logic [14:0] r;
    logic        p;
    logic [15:0] s;
    v = m_msg;
    if (flip_pos != 7'h00) begin
      v[64 - flip_pos] = ~v[64 - flip_pos];
    end
    r = 15'h0000;
    p = 1'b0;
    for (int i = 63; i >= 1; i--) begin
      p ^= v[i];
      r = div_step(r, v[i] ^ (i == 1));
    end
    for (int j = 0; j < 15; j++) begin
      s[j] = r[14 - j];
    end
    s[15] = p ^ v[0];
    exp_rx.push_back({(r == 15'h0000) && !s[15], s});
  endtask : expect_rx

  task automatic model_byte(input logic [7:0] b);
    logic [14:0] ck;
    for (int i = 7; i >= 0; i--) begin
      m_rem = div_step(m_rem, b[i]);
      put_bit(b[i]);
    end
    m_cnt++;
    if (m_cnt == 6) begin
      if (cksum_ins_en) begin
        ck = m_rem ^ fmc_pkg::LAST_INV;
        for (int i = 14; i >= 0; i--) begin
          put_bit(ck[i]);
        end
        put_bit(m_par);
        expect_rx();
      end
      model_clear();
    end
  endtask : model_byte

  // ----------------------------------------------------------------------
  // Drivers and checks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] want);
    n_tests++;
    if (got !== want) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h, want %h", $time, got, want);
    end
  endtask : chk

  // Valid stays up between bytes so the strobe is never rewritten.
  task automatic send_byte();
    logic [7:0] b;
    logic       tk;
    b = 8'($urandom);
    tx_byte <= b;
    tx_byte_valid <= 1'b1;
    do begin
      tk = tx_byte_ready;
      @(negedge mclk);
    end while (tk !== 1'b1);
    model_byte(b);
  endtask : send_byte

  task automatic send_n(input int n);
    for (int i = 0; i < n; i++) begin
      send_byte();
    end
    tx_byte_valid <= 1'b0;
  endtask : send_n

  task automatic restart(input logic [6:0] f);
    flip_pos <= f;
    rx_msg_start <= 1'b1;
    @(negedge mclk);
    rx_msg_start <= 1'b0;
  endtask : restart

  task automatic wait_done();
    int n;
    n = 0;
    while ((exp_tx.size() != 0 || exp_rx.size() != 0 || tx_idle !== 1'b1)
           && n < 4000) begin
      @(negedge mclk);
      n++;
    end
    chk(17'({exp_tx.size() != 0, exp_rx.size() != 0, tx_idle}), 17'h1);
  endtask : wait_done

  task automatic wrap_up();
    $display("Checks made: %0d, mismatches: %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : wrap_up

  // An empty queue yields unknown, so a surplus result never matches.
  function automatic logic pop_tx();
    return exp_tx.size() != 0 ? exp_tx.pop_front() : 1'bx;
  endfunction : pop_tx

  function automatic logic [16:0] pop_rx();
    return exp_rx.size() != 0 ? exp_rx.pop_front() : 17'hx;
  endfunction : pop_rx

  // Outputs are sampled at the falling edge, well after they settle.
  always @(negedge mclk) begin
    if (tx_bit_stb === 1'b1) begin
      chk({16'h0000, tx_bit}, {16'h0000, pop_tx()});
    end
    if (syndrome_stb === 1'b1) begin
      chk({cksum_true, syndrome}, pop_rx());
    end
  end

  // ----------------------------------------------------------------------
  // Clock, watchdog and scenarios
  // ----------------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Longest legal run is near 4300 clocks, so 30000 means a hang.
  initial begin
    repeat (30000) @(posedge mclk);
    n_mismatch++;
    wrap_up();
  end

  initial begin
    void'($urandom(32'h6e6dcd8a));
    rstn = 1'b0;
    cksum_ins_en = 1'b1;
    tx_byte = 8'h00;
    tx_byte_valid = 1'b0;
    rx_msg_start = 1'b0;
    tick_en = 1'b0;
    slow = 1'b0;
    flip_pos = 7'h00;
    flips = '{7'h00, 7'h01, 7'h28, 7'h30, 7'h3f, 7'h40, 7'h00};
    flips[6] = 7'($urandom_range(64, 1));
    model_clear();
    repeat (2) @(negedge mclk);
    rstn = 1'b1;
    repeat (3) @(negedge mclk);
    chk({13'h0, tx_idle, tx_byte_ready, tx_bit_stb, syndrome_stb}, 17'hc);
    chk({cksum_true, syndrome}, 17'h00000);
    restart(7'h00);
    tick_en <= 1'b1;
    send_n(12);
    wait_done();
    foreach (flips[i]) begin
      restart(flips[i]);
      send_n(6);
      wait_done();
    end
    restart(7'h00);
    send_n(3);
    wait_done();
    model_clear();
    restart(7'h00);
    send_n(6);
    wait_done();
    cksum_ins_en <= 1'b0;
    send_n(6);
    wait_done();
    cksum_ins_en <= 1'b1;
    tick_en <= 1'b0;
    restart(7'h00);
    k = 0;
    while (tx_byte_ready === 1'b1 && k < 12) begin
      send_byte();
      k++;
    end
    chk(17'(k), 17'(fmc_pkg::FIFO_DEPTH + 1));
    slow <= 1'b1;
    tick_en <= 1'b1;
    send_n(12 - k);
    wait_done();
    wrap_up();
  end
endmodule : fmc_codec_tb_top
